// ---- src/rism_host_end.sv ----
/*
 * Host-side end: samples the three radio pins, drives its own pin data and
 * issues flag-clear strobes. Assumes user inputs are on MCLK.
 */
`timescale 1ns/1ps
module rism_host_end (
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    rism_link_if.host       LINK,
    input  wire logic [8:0] CLEAR_REQ,
    input  wire logic [2:0] PIN_DRIVE_EN,
    input  wire logic [2:0] PIN_DRIVE_VAL,
    output logic [2:0]      PIN_LEVEL
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [8:0] clr_reg;
    logic [2:0] oe_reg;
    logic [2:0] o_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pins are the wire level on the link (radio drive, host drive or pull-up); two flops before the user sees them.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end else begin
            meta_reg <= LINK.pin_lvl;
            sync_reg <= meta_reg;
        end
    end
    assign PIN_LEVEL = sync_reg;

    // Clear strobes are registered one cycle; each bit is one clear request.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            clr_reg <= 9'h000;
        end else begin
            clr_reg <= CLEAR_REQ;
        end
    end
    assign LINK.flag_clr = clr_reg;

    // Host pin drive, e.g. serial data into the radio.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            oe_reg <= 3'h0;
            o_reg  <= 3'h0;
        end else begin
            oe_reg <= PIN_DRIVE_EN;
            o_reg  <= PIN_DRIVE_VAL;
        end
    end
    assign LINK.host_pin_oe = oe_reg;
    assign LINK.host_pin_o  = o_reg;
endmodule

// ---- src/rism_link_if.sv ----
/*
 * Link between the radio end and the host end: three two-way pins and the
 * host flag-clear strobe. Assumes both ends run on the same MCLK.
 */
`timescale 1ns/1ps
interface rism_link_if;
    logic [2:0] dev_pin_o;
    logic [2:0] dev_pin_oe;
    logic [2:0] host_pin_o;
    logic [2:0] host_pin_oe;
    logic [2:0] pin_lvl;
    logic [8:0] flag_clr;

    // Wire level: radio drive first, then host drive, else pulled high.
    assign pin_lvl = (dev_pin_oe & dev_pin_o) | (~dev_pin_oe & host_pin_oe & host_pin_o)
                     | (~dev_pin_oe & ~host_pin_oe);

    modport radio (output dev_pin_o, output dev_pin_oe, input pin_lvl, input flag_clr);
    modport host  (output host_pin_o, output host_pin_oe, input pin_lvl, output flag_clr);
endinterface

// ---- src/rism_pkg.sv ----
/*
 * Shared constants for the radio interrupt source mapper: register map, field
 * positions, reset values, selector codes, pin function codes and radio states.
 * Assumes both link ends and the source multiplexer use package-qualified names.
 */
package rism_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the Avalon-MM slave.
    localparam logic [3:0] ADDR_IRQ_CFG  = 4'h0;
    localparam logic [3:0] ADDR_PIN_CFG  = 4'h4;
    localparam logic [3:0] ADDR_FLAGS    = 4'h8;
    localparam logic [3:0] ADDR_STATUS   = 4'hC;

    localparam int SEL_W         = 5;
    localparam int FIRST_SEL_LSB = 0;
    localparam int SECOND_SEL_LSB = 8;
    localparam int POLARITY_BIT  = 16;
    localparam int FN_W          = 3;
    localparam int PIN_A_LSB     = 0;
    localparam int PIN_B_LSB     = 4;
    localparam int PIN_C_LSB     = 8;
    localparam int NUM_PINS      = 3;
    localparam int NUM_FLAGS     = 9;
    localparam int NUM_SRC       = 26;

    localparam logic [SEL_W-1:0]     SEL_RESET   = 5'h00;
    localparam logic                 POL_RESET   = 1'b0;
    localparam logic [FN_W-1:0]      FN_RESET    = 3'h7;
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 9'h000;

    ////////////////////////////////////////////////////////////////////////////
    // Latched flag positions in the flag register.
    localparam int FL_PREAMBLE = 0;
    localparam int FL_SYNC     = 1;
    localparam int FL_NODE     = 2;
    localparam int FL_CRC      = 3;
    localparam int FL_PKT      = 4;
    localparam int FL_SLEEP    = 5;
    localparam int FL_RXTMO    = 6;
    localparam int FL_TXDONE   = 7;
    localparam int FL_FINISHED = 8;

    // Selector codes whose source is a latched flag, in flag order.
    localparam logic [SEL_W-1:0] SEL_FLAG_FIRST = 5'h03;
    localparam logic [SEL_W-1:0] SEL_FINISHED   = 5'h19;
    localparam logic [SEL_W-1:0] SEL_LAST       = 5'h19;

    ////////////////////////////////////////////////////////////////////////////
    // Pin function codes; legality differs per pin.
    typedef enum logic [FN_W-1:0] {
        RISM_FN_DATA   = 3'h0,
        RISM_FN_IRQ1   = 3'h1,
        RISM_FN_IRQ2   = 3'h3,
        RISM_FN_STROBE = 3'h2,
        RISM_FN_ANT    = 3'h6,
        RISM_FN_SYSCLK = 3'h4
    } rism_fn_t;

    // Bit n set means function code n is legal on that pin.
    localparam logic [7:0] LEGAL_PIN_A = 8'h4F;
    localparam logic [7:0] LEGAL_PIN_B = 8'h4F;
    localparam logic [7:0] LEGAL_PIN_C = 8'h1D;

    // Radio operating states.
    typedef enum logic [3:0] {
        RISM_ST_IDLE  = 4'h0,
        RISM_ST_SLEEP = 4'h1,
        RISM_ST_STBY  = 4'h2,
        RISM_ST_RFS   = 4'h3,
        RISM_ST_TFS   = 4'h4,
        RISM_ST_RX    = 4'h5,
        RISM_ST_TX    = 4'h6
    } rism_state_t;

endpackage

// ---- src/rism_radio_end.sv ----
/*
 * Radio-side end: latched status flags, two interrupt source multiplexers,
 * pin function routing for three pins and an Avalon-MM register slave.
 * Assumes status inputs come from radio logic on MCLK; pins arrive unsynchronised.
 */
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module rism_radio_end (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    rism_link_if.radio       LINK,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [3:0]  RADIO_STATE,
    input  wire logic        SIGNAL_STRENGTH_VALID,
    input  wire logic        PREAMBLE_FOUND,
    input  wire logic        SYNC_FOUND,
    input  wire logic        NODE_FOUND,
    input  wire logic        CRC_GOOD,
    input  wire logic        PACKET_RECEIVED,
    input  wire logic        SLEEP_TIMER_EXPIRED,
    input  wire logic        RECEIVE_TIMER_EXPIRED,
    input  wire logic        TRANSMIT_DONE,
    input  wire logic        LINE_CODE_ERROR,
    input  wire logic        NODE_MISMATCH,
    input  wire logic        COLLISION_SEEN,
    input  wire logic        RXQ_HAS_DATA,
    input  wire logic        RXQ_ABOVE_LEVEL,
    input  wire logic        RXQ_FULL,
    input  wire logic        RXQ_BYTE_PULSE,
    input  wire logic        RXQ_OVERRUN,
    input  wire logic        TXQ_HAS_DATA,
    input  wire logic        TXQ_ABOVE_LEVEL,
    input  wire logic        TXQ_FULL,
    input  wire logic        LOW_SUPPLY_FLAG,
    input  wire logic        TX_DATA_BIT,
    input  wire logic        BIT_STROBE,
    input  wire logic        ANTENNA_SWITCH,
    input  wire logic        SYSCLK_DIV,
    output logic             RX_DATA_BIT,
    output logic             DECODER_RESET,
    output logic             DECODER_HOLD
);
    logic [rism_pkg::SEL_W-1:0]     sel_first_reg;
    logic [rism_pkg::SEL_W-1:0]     sel_second_reg;
    logic                           polarity_reg;
    logic [rism_pkg::FN_W-1:0]      pin_fn_reg [rism_pkg::NUM_PINS];
    logic [rism_pkg::NUM_FLAGS-1:0] flags_reg;
    logic [rism_pkg::NUM_FLAGS-1:0] flag_set;
    logic [rism_pkg::NUM_FLAGS-1:0] flag_clr;
    logic [rism_pkg::NUM_SRC-1:0]   src;
    logic                           irq_first;
    logic                           irq_second;
    logic                           rd_done_reg;
    logic                           hold_reg;
    logic                           dec_rst_reg;
    logic [2:0]                     pin_meta_reg;
    logic [2:0]                     pin_sync_reg;
    logic [2:0]                     data_pin;
    logic                           rx_active;
    logic                           tx_active;
    logic                           wr_flags;
    logic                           pkt_end;

    ////////////////////////////////////////////////////////////////////////////
    // Latched flags: hardware events set, host strobe or write-one clears.
    assign pkt_end  = PACKET_RECEIVED | LINE_CODE_ERROR | NODE_MISMATCH | COLLISION_SEEN;
    assign flag_set = {pkt_end, TRANSMIT_DONE, RECEIVE_TIMER_EXPIRED, SLEEP_TIMER_EXPIRED,
                       PACKET_RECEIVED, CRC_GOOD,
                       NODE_FOUND, SYNC_FOUND, PREAMBLE_FOUND};
    assign wr_flags = AVS_WRITE && (AVS_ADDRESS == rism_pkg::ADDR_FLAGS);
    assign flag_clr = LINK.flag_clr | (wr_flags ? AVS_WRITEDATA[rism_pkg::NUM_FLAGS-1:0] : '0);

    // The set term is applied last so a same-cycle event is never lost.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            flags_reg <= rism_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoder control: errors reset it, a collision freezes it until the host
    // clears the packet-finished flag, because the host must choose what next.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hold_reg    <= 1'b0;
            dec_rst_reg <= 1'b0;
        end else begin
            dec_rst_reg <= LINE_CODE_ERROR | NODE_MISMATCH;
            if (COLLISION_SEEN) begin
                hold_reg <= 1'b1;
            end else if (flag_clr[rism_pkg::FL_FINISHED]) begin
                hold_reg <= 1'b0;
            end
        end
    end
    assign DECODER_RESET = dec_rst_reg;
    assign DECODER_HOLD  = hold_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Source vector, indexed by selector code.
    assign rx_active = (RADIO_STATE == rism_pkg::RISM_ST_RFS) || (RADIO_STATE == rism_pkg::RISM_ST_RX);
    assign tx_active = (RADIO_STATE == rism_pkg::RISM_ST_TFS) || (RADIO_STATE == rism_pkg::RISM_ST_TX);
    always_comb begin
        src        = '0;
        src[0]     = rx_active;
        src[1]     = tx_active;
        src[2]     = SIGNAL_STRENGTH_VALID;
        src[10:3]  = flags_reg[rism_pkg::FL_TXDONE:rism_pkg::FL_PREAMBLE];
        src[11]    = RXQ_HAS_DATA;
        src[12]    = RXQ_ABOVE_LEVEL;
        src[13]    = RXQ_FULL;
        src[14]    = RXQ_BYTE_PULSE;
        src[15]    = RXQ_OVERRUN;
        src[16]    = TXQ_HAS_DATA;
        src[17]    = TXQ_ABOVE_LEVEL;
        src[18]    = TXQ_FULL;
        src[19]    = (RADIO_STATE == rism_pkg::RISM_ST_STBY);
        src[20]    = rx_active ^ tx_active ? (RADIO_STATE == rism_pkg::RISM_ST_RFS)
                     || (RADIO_STATE == rism_pkg::RISM_ST_TFS) : 1'b0;
        src[21]    = (RADIO_STATE == rism_pkg::RISM_ST_RX);
        src[22]    = (RADIO_STATE == rism_pkg::RISM_ST_TX);
        src[23]    = LOW_SUPPLY_FLAG;
        src[24]    = rx_active | tx_active;
        src[25]    = flags_reg[rism_pkg::FL_FINISHED];
    end

    // Two identical multiplexers, each with its own selector.
    rism_src_mux u_mux_first (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .src      (src),
        .sel      (sel_first_reg),
        .polarity (polarity_reg),
        .irq_reg  (irq_first)
    );
    rism_src_mux u_mux_second (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .src      (src),
        .sel      (sel_second_reg),
        .polarity (polarity_reg),
        .irq_reg  (irq_second)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin routing. An illegal function code leaves the pin undriven. A pin in
    // data mode drives only while transmitting and is an input otherwise.
    genvar gi;
    generate
        for (gi = 0; gi < rism_pkg::NUM_PINS; gi++) begin : g_pin
            localparam logic [7:0] LEGAL = (gi == 0) ? rism_pkg::LEGAL_PIN_A :
                                           (gi == 1) ? rism_pkg::LEGAL_PIN_B :
                                                       rism_pkg::LEGAL_PIN_C;
            always_comb begin
                LINK.dev_pin_o[gi]  = 1'b0;
                LINK.dev_pin_oe[gi] = LEGAL[pin_fn_reg[gi]];
                data_pin[gi]        = 1'b0;
                case (pin_fn_reg[gi])
                    rism_pkg::RISM_FN_DATA: begin
                        LINK.dev_pin_o[gi]  = TX_DATA_BIT;
                        LINK.dev_pin_oe[gi] = (RADIO_STATE == rism_pkg::RISM_ST_TX);
                        data_pin[gi]        = 1'b1;
                    end
                    rism_pkg::RISM_FN_IRQ1:   LINK.dev_pin_o[gi] = irq_first;
                    rism_pkg::RISM_FN_IRQ2:   LINK.dev_pin_o[gi] = irq_second;
                    rism_pkg::RISM_FN_STROBE: LINK.dev_pin_o[gi] = BIT_STROBE;
                    rism_pkg::RISM_FN_ANT:    LINK.dev_pin_o[gi] = ANTENNA_SWITCH;
                    rism_pkg::RISM_FN_SYSCLK: LINK.dev_pin_o[gi] = SYSCLK_DIV;
                    default:                  LINK.dev_pin_oe[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Pin levels pass two flops before the data-in selection reads them.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= LINK.pin_lvl;
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign RX_DATA_BIT = |(pin_sync_reg & data_pin);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sel_first_reg  <= rism_pkg::SEL_RESET;
            sel_second_reg <= rism_pkg::SEL_RESET;
            polarity_reg   <= rism_pkg::POL_RESET;
        end else if (AVS_WRITE && AVS_ADDRESS == rism_pkg::ADDR_IRQ_CFG) begin
            sel_first_reg  <= AVS_WRITEDATA[rism_pkg::FIRST_SEL_LSB +: rism_pkg::SEL_W];
            sel_second_reg <= AVS_WRITEDATA[rism_pkg::SECOND_SEL_LSB +: rism_pkg::SEL_W];
            polarity_reg   <= AVS_WRITEDATA[rism_pkg::POLARITY_BIT];
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_fn_reg[0] <= rism_pkg::FN_RESET;
            pin_fn_reg[1] <= rism_pkg::FN_RESET;
            pin_fn_reg[2] <= rism_pkg::FN_RESET;
        end else if (AVS_WRITE && AVS_ADDRESS == rism_pkg::ADDR_PIN_CFG) begin
            pin_fn_reg[0] <= AVS_WRITEDATA[rism_pkg::PIN_A_LSB +: rism_pkg::FN_W];
            pin_fn_reg[1] <= AVS_WRITEDATA[rism_pkg::PIN_B_LSB +: rism_pkg::FN_W];
            pin_fn_reg[2] <= AVS_WRITEDATA[rism_pkg::PIN_C_LSB +: rism_pkg::FN_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads take one wait cycle so read data comes from a flop; writes do not wait.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_done_reg  <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            rd_done_reg <= AVS_READ && !rd_done_reg;
            if (AVS_READ && !rd_done_reg) begin
                case (AVS_ADDRESS)
                    rism_pkg::ADDR_IRQ_CFG: AVS_READDATA <= {15'h0000, polarity_reg, 3'h0, sel_second_reg,
                                                             3'h0, sel_first_reg};
                    rism_pkg::ADDR_PIN_CFG: AVS_READDATA <= {21'h00_0000, pin_fn_reg[2], 1'b0,
                                                             pin_fn_reg[1], 1'b0, pin_fn_reg[0]};
                    rism_pkg::ADDR_FLAGS:   AVS_READDATA <= {23'h00_0000, flags_reg};
                    rism_pkg::ADDR_STATUS:  AVS_READDATA <= {24'h00_0000, hold_reg, 1'b0,
                                                             irq_second, irq_first, RADIO_STATE};
                    default:                AVS_READDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign AVS_WAITREQUEST = AVS_READ && !rd_done_reg;
endmodule

// ---- src/rism_src_mux.sv ----
/*
 * One interrupt output: picks a source by selector and applies polarity.
 * Assumes the source vector is on MCLK and the selector is a register.
 */
`timescale 1ns/1ps
module rism_src_mux (
    input  wire logic                                     clk,
    input  wire logic                                     rst,
    input  wire logic [rism_pkg::NUM_SRC-1:0]             src,
    input  wire logic [rism_pkg::SEL_W-1:0]               sel,
    input  wire logic                                     polarity,
    output logic                                          irq_reg
);
    logic picked;

    ////////////////////////////////////////////////////////////////////////////
    // Unassigned codes pick 0, so a bad selector outputs the polarity bit.
    always_comb begin
        if (sel <= rism_pkg::SEL_LAST) begin
            picked = src[sel];
        end else begin
            picked = 1'b0;
        end
    end

    // Registered so the pin never glitches while the selector changes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= picked ^ polarity;
        end
    end
endmodule

// ---- verification/rism_link_sva.sv ----
/* Assertions on the decoder controls and the register bus of the radio end.
   Assumes every input is sampled on MCLK and SYS_RST is asynchronous, active high. */
`timescale 1ns/1ps
module rism_link_sva (
    input wire logic       MCLK,
    input wire logic       SYS_RST,
    input wire logic [2:0] dev_pin_oe,
    input wire logic [8:0] flag_clr,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       LINE_CODE_ERROR,
    input wire logic       NODE_MISMATCH,
    input wire logic       COLLISION_SEEN,
    input wire logic       DECODER_RESET,
    input wire logic       DECODER_HOLD
);
    ////////////////////////////////////////////////////////////////////////////
    // One clock domain, so reset masks every check from one place.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    AST_ERR_RESET: assert property ((LINE_CODE_ERROR || NODE_MISMATCH) |=> DECODER_RESET)
        else $error("decoder not reset after a decode error");
    AST_NO_SPUR_RESET: assert property (!LINE_CODE_ERROR && !NODE_MISMATCH |=> !DECODER_RESET)
        else $error("decoder reset without a decode error");
    AST_HOLD_SET: assert property (COLLISION_SEEN |=> DECODER_HOLD)
        else $error("decoder not held after a collision");
    AST_HOLD_CLEAR: assert property (flag_clr[8] && !COLLISION_SEEN |=> !DECODER_HOLD)
        else $error("decoder hold survived a clear");
    AST_HOLD_CAUSE: assert property ($rose(DECODER_HOLD) |-> $past(COLLISION_SEEN))
        else $error("decoder hold rose without a collision");
    AST_PINS_IDLE: assert property ($fell(SYS_RST) |-> dev_pin_oe == 3'b000)
        else $error("pins driven right after reset");
    AST_READ_WAIT: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
        else $error("write stalled");
endmodule

// ---- verification/tb_radio_irq_source_mapper.sv ----
/* Self-checking bench joining the radio end and the host end over the link.
   Assumes the design package and the link interface are compiled first. */
`timescale 1ns/1ps
module tb_radio_irq_source_mapper;
    logic        MCLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [3:0]  addr = 4'h0, st = 4'h0, drv = 4'h0;
    logic        rd = 1'b0, wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, q;
    logic [11:0] ev = 12'h000;
    logic [8:0]  lv = 9'h000, clr = 9'h000;
    logic [2:0]  hen = 3'h0, hval = 3'h0;
    logic [4:0]  codes [7] = '{5'h00, 5'h01, 5'h13, 5'h14, 5'h15, 5'h16, 5'h18};
    logic [4:0]  lcodes [9] = '{5'h02, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h17};
    wire  [31:0] rdata;
    wire         waitreq, dreset, dhold, rxbit;
    wire  [2:0]  plev;
    int          error_cnt = 0, comparisons = 0;

    rism_link_if u_rism_link_if ();
    rism_radio_end u_rism_radio_end (.MCLK(MCLK), .SYS_RST(SYS_RST), .LINK(u_rism_link_if), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .RADIO_STATE(st), .SIGNAL_STRENGTH_VALID(lv[0]), .PREAMBLE_FOUND(ev[0]), .SYNC_FOUND(ev[1]),
        .NODE_FOUND(ev[2]), .CRC_GOOD(ev[3]), .PACKET_RECEIVED(ev[4]), .SLEEP_TIMER_EXPIRED(ev[5]),
        .RECEIVE_TIMER_EXPIRED(ev[6]), .TRANSMIT_DONE(ev[7]), .LINE_CODE_ERROR(ev[8]), .NODE_MISMATCH(ev[9]),
        .COLLISION_SEEN(ev[10]), .RXQ_HAS_DATA(lv[1]), .RXQ_ABOVE_LEVEL(lv[2]), .RXQ_FULL(lv[3]),
        .RXQ_BYTE_PULSE(ev[11]), .RXQ_OVERRUN(lv[4]), .TXQ_HAS_DATA(lv[5]), .TXQ_ABOVE_LEVEL(lv[6]),
        .TXQ_FULL(lv[7]), .LOW_SUPPLY_FLAG(lv[8]), .TX_DATA_BIT(drv[0]), .BIT_STROBE(drv[1]),
        .ANTENNA_SWITCH(drv[2]), .SYSCLK_DIV(drv[3]), .RX_DATA_BIT(rxbit), .DECODER_RESET(dreset),
        .DECODER_HOLD(dhold));
    rism_host_end u_rism_host_end (.MCLK(MCLK), .SYS_RST(SYS_RST), .LINK(u_rism_link_if), .CLEAR_REQ(clr),
        .PIN_DRIVE_EN(hen), .PIN_DRIVE_VAL(hval), .PIN_LEVEL(plev));
    rism_link_sva u_rism_link_sva (.MCLK(MCLK), .SYS_RST(SYS_RST), .dev_pin_oe(u_rism_link_if.dev_pin_oe),
        .flag_clr(u_rism_link_if.flag_clr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WAITREQUEST(waitreq),
        .LINE_CODE_ERROR(ev[8]), .NODE_MISMATCH(ev[9]), .COLLISION_SEEN(ev[10]), .DECODER_RESET(dreset),
        .DECODER_HOLD(dhold));

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock, 10 ns period.
    always #5 MCLK = ~MCLK;

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask

    // Compares with case equality so an unknown never passes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; the request stands until waitrequest is sampled low.
    task automatic avs(input logic wnr, input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        addr <= a;
        wdata <= d;
        wr <= wnr;
        rd <= ~wnr;
        do @(posedge MCLK); while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        avs(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask

    // Events are one-cycle pulses, as the radio logic gives them.
    task automatic pulse(input logic [11:0] m);
        @(posedge MCLK);
        ev <= m;
        @(posedge MCLK);
        ev <= 12'h000;
    endtask

    task automatic selboth(input logic [4:0] c, input logic pol);
        avs(1'b1, rism_pkg::ADDR_IRQ_CFG, {15'h0000, pol, 3'h0, c, 3'h0, c});
        tick(6);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog sized well above the roughly 1100 cycles the tests take.
    initial begin
        tick(20000);
        error_cnt++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        int  f, n;
        logic a, c, e;
        tick(16);
        SYS_RST <= 1'b0;
        rdchk(rism_pkg::ADDR_IRQ_CFG, 32'h0000_0000);
        rdchk(rism_pkg::ADDR_PIN_CFG, 32'h0000_0777);
        rdchk(4'h2, 32'h0000_0000);
        $display("reset values done");
        // Driven pins show the low sources; undriven pins float to the pull-up.
        for (f = 0; f < 8; f++) begin
            avs(1'b1, rism_pkg::ADDR_PIN_CFG, {21'h00_0000, f[2:0], 1'b0, f[2:0], 1'b0, f[2:0]});
            tick(4);
            a = (f == 1 || f == 2 || f == 3 || f == 6);
            c = (f == 2 || f == 3 || f == 4);
            check(32'(plev), 32'({~c, ~a, ~a}));
        end
        // Data mode: the pins are inputs outside transmit and are driven by the radio in transmit.
        avs(1'b1, rism_pkg::ADDR_PIN_CFG, 32'h0000_0000);
        hen <= 3'b111;
        hval <= 3'b010;
        tick(6);
        check(32'(plev), 32'h0000_0002);
        check(32'(rxbit), 32'h0000_0001);
        st <= 4'h6;
        tick(6);
        check(32'(plev), 32'h0000_0000);
        check(32'(rxbit), 32'h0000_0000);
        st <= 4'h0;
        hen <= 3'b000;
        avs(1'b1, rism_pkg::ADDR_PIN_CFG, 32'h0000_0431);
        $display("pin functions done");
        for (f = 0; f < 49; f++) begin
            st <= 4'(f / 7);
            selboth(codes[f % 7], 1'b0);
            n = f / 7;
            case (f % 7)
                0: e = (n == 3 || n == 5);
                1: e = (n == 4 || n == 6);
                2: e = (n == 2);
                3: e = (n == 3 || n == 4);
                4: e = (n == 5);
                5: e = (n == 6);
                default: e = (n >= 3 && n <= 6);
            endcase
            check(32'(plev[1:0]), 32'({e, e}));
        end
        st <= 4'h0;
        for (f = 0; f < 9; f++) begin
            lv <= 9'(1 << f);
            selboth(lcodes[f], 1'b0);
            check(32'(plev[1:0]), 32'h0000_0003);
            lv <= 9'h000;
            tick(6);
            check(32'(plev[1:0]), 32'h0000_0000);
        end
        $display("level sources done");
        for (f = 0; f < 11; f++) begin
            selboth((f < 8) ? 5'(f + 3) : 5'h19, 1'b0);
            pulse(12'(1 << f));
            tick(12);
            check(32'(plev[1:0]), 32'h0000_0003);
            rdchk(rism_pkg::ADDR_FLAGS, (f < 8) ? ((32'h1 << f) | ((f == 4) ? 32'h100 : 32'h0)) : 32'h100);
            rdchk(rism_pkg::ADDR_STATUS, (f == 10) ? 32'h0000_00B0 : 32'h0000_0030);
            if (f % 2)
                avs(1'b1, rism_pkg::ADDR_FLAGS, 32'h0000_01FF);
            else begin
                @(posedge MCLK);
                clr <= 9'h1FF;
                @(posedge MCLK);
                clr <= 9'h000;
            end
            tick(6);
            rdchk(rism_pkg::ADDR_STATUS, 32'h0000_0000);
        end
        @(posedge MCLK);
        clr <= 9'h100;
        @(posedge MCLK);
        clr <= 9'h000;
        ev <= 12'h400;
        @(posedge MCLK);
        ev <= 12'h000;
        tick(4);
        rdchk(rism_pkg::ADDR_FLAGS, 32'h0000_0100);
        avs(1'b1, rism_pkg::ADDR_FLAGS, 32'h0000_0100);
        $display("latched flags done");
        selboth(5'h0E, 1'b0);
        pulse(12'h800);
        n = 0;
        repeat (8) begin
            @(posedge MCLK);
            n += int'(plev[0]);
        end
        check(32'(n), 32'h0000_0001);
        selboth(5'h1A, 1'b1);
        check(32'(plev[1:0]), 32'h0000_0003);
        selboth(5'h1F, 1'b0);
        check(32'(plev[1:0]), 32'h0000_0000);
        lv <= 9'h001;
        selboth(5'h02, 1'b1);
        check(32'(plev[1:0]), 32'h0000_0000);
        $display("pulse and polarity done");
        print_verdict();
    end
endmodule
